// [shared/hpps_pkg.sv]
// Constants and types for the hub port power supervisor
package hpps_pkg;
  localparam int NPORT = 8;
  localparam int NCH = 17;
  localparam int SW = 16;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLOT_NS = 140000;
  localparam int SLOT_CYC = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] SLOT_LAST = 12'(SLOT_CYC - 1);
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US = TICK_NS / 1000;
  localparam int OC_DELAY_US = 1000;
  localparam int REC_DELAY_US = 70000;
  localparam int CYCLE_OFF_US = 100000;
  // One extra tick covers the unknown phase of the tick divider
  localparam logic [6:0] OC_TICKS = 7'((OC_DELAY_US + TICK_US - 1) / TICK_US + 1);
  localparam logic [6:0] REC_TICKS = 7'((REC_DELAY_US + TICK_US - 1) / TICK_US + 1);
  localparam logic [6:0] CYCLE_TICKS = 7'((CYCLE_OFF_US + TICK_US - 1) / TICK_US + 1);
  localparam logic [1:0] OV_RUN = 2'h3;
  localparam int FILT_SHIFT = 2;
  localparam logic [4:0] CH_SUPPLY = 5'h10;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PORT_EN = 8'h04;
  localparam logic [7:0] REG_PORT_MODE = 8'h08;
  localparam logic [7:0] REG_OC_FLAGS = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_OV_THRESH = 8'h14;
  localparam logic [7:0] REG_LIMIT_BASE = 8'h20;
  localparam logic [7:0] REG_MEAS_BASE = 8'h40;
  localparam logic [7:0] REG_MEAS_END = 8'h84;
  localparam int CTRL_TOGGLE_BIT = 0;
  localparam int CTRL_UPMODE_LSB = 1;
  localparam logic CTRL_TOGGLE_RST = 1'b1;
  localparam logic [7:0] PORT_EN_RST = 8'hFF;
  localparam logic [15:0] PORT_MODE_RST = 16'h0000;
  localparam logic [15:0] OV_THRESH_RST = 16'h02A3;
  localparam logic [11:0] LIMIT_RST = 12'hFFF;
  localparam int SY_BUSPWR = 0;
  localparam int SY_CTRL = 1;
  localparam int SY_UP1C = 2;
  localparam int SY_UP2C = 3;
  localparam int SY_UP1E = 4;
  localparam int SY_UP2E = 5;
  localparam int NSYNC = 6;
  typedef enum logic [1:0] {CFG_SDP, CFG_CDP, CFG_CDP_DCP, CFG_DCP} hpps_cfg_t;
  typedef enum logic [1:0] {OFFER_NONE, OFFER_SDP, OFFER_CDP, OFFER_DCP} hpps_offer_t;
  typedef enum logic [1:0] {UP_AUTO, UP_FIRST, UP_SECOND} hpps_up_mode_t;
  typedef enum logic [1:0] {LINK_CTRL, LINK_UP_FIRST, LINK_UP_SECOND} hpps_link_t;
  typedef enum logic {TG_IDLE, TG_OFF} hpps_tg_t;
endpackage

// [design/hpps_ema.sv]
// Per-channel exponential moving average filter
`timescale 1ns/1ns
module hpps_ema (
  input  wire logic                     clk_sys_in,
  input  wire logic                     arst_n_in,
  input  wire logic                     upd_in,
  input  wire logic [4:0]               ch_in,
  input  wire logic [hpps_pkg::SW-1:0]  sample_in,
  input  wire logic [4:0]               rd_ch_in,
  output logic      [hpps_pkg::SW-1:0]  rd_val_out
);
  import hpps_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][SW-1:0] acc;
  } hpps_ema_t;

  hpps_ema_t r;
  hpps_ema_t next_r;
  logic signed [SW:0] diff;
  logic signed [SW:0] step;

  always_comb begin
    next_r = r;
    diff = $signed({sample_in[SW-1], sample_in}) - $signed({r.acc[ch_in][SW-1], r.acc[ch_in]});
    step = diff >>> FILT_SHIFT;
    if (upd_in && ch_in < 5'(NCH)) begin
      next_r.acc[ch_in] = r.acc[ch_in] + step[SW-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rd_val_out = (rd_ch_in < 5'(NCH)) ? r.acc[rd_ch_in] : '0;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  property p_ema_step;
    logic signed [SW:0] d;
    (upd_in && ch_in == 5'h00, d = diff) |=> r.acc[0] == $past(r.acc[0]) + SW'(d >>> FILT_SHIFT);
  endproperty
  a_ema_step: assert property (p_ema_step) else $error("filter step wrong");
endmodule

// [design/hpps_sup.sv]
// Port power supervisor: charging modes, measurement, faults, host select
//Contract
//- SDP/CDP with enumeration, DCP without it
//- Auto power toggle enabled out of reset
//- Toggle SDP/CDP port power on enumeration change
//- SDP port unpowered while not enumerated
//- CDP/DCP port: CDP enumerated, else DCP
//- Sample all port voltages, currents, supply voltage
//- Voltage then current per port, then next
//- Each conversion slot lasts 140 us
//- Filter adds quarter of sample error
//- Step settles 10% in 8, 1% in 16
//- Raw current sample above limit trips port
//- Trip sets flag, power off after delay
//- Three bad samples in a row cut power
//- Power returns after recovery delay once clear
//- Bus-powered system keeps all ports off
//- Control cable present: control link on it
//- Otherwise control link shares active upstream
//- Control port never carries hub traffic
//- Exactly one upstream host drives downstream
//- Automatic selection prefers first upstream port
//- Fault recovery delay about 70 ms
//- Overcurrent disable delay 1 to 2 ms
//- Twelve-bit current limit per port
`timescale 1ns/1ns
module hpps_sup #(
  parameter int unsigned TICK_CYC = hpps_pkg::TICK_CYC_DEF
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     arst_n_in,
  input  wire logic [7:0]               reg_addr_in,
  input  wire logic [31:0]              reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [31:0]              reg_rdata_out,
  output logic                          adc_start_out,
  output logic      [4:0]               adc_chan_out,
  input  wire logic [hpps_pkg::SW-1:0]  adc_data_in,
  input  wire logic                     bus_powered_in,
  input  wire logic                     ctrl_cable_in,
  input  wire logic                     upstream_port_first_conn_in,
  input  wire logic                     upstream_port_second_conn_in,
  input  wire logic                     upstream_port_first_enum_in,
  input  wire logic                     upstream_port_second_enum_in,
  output logic      [hpps_pkg::NPORT-1:0] port_power_out,
  output logic      [15:0]              port_offer_out,
  output logic                          host_sel_out,
  output logic      [1:0]               link_route_out
);
  import hpps_pkg::*;

  typedef struct packed {
    logic [NSYNC-1:0]        s1;
    logic [NSYNC-1:0]        s2;
    logic [NSYNC-1:0]        s3;
    logic [NSYNC-1:0]        sy;
    logic [11:0]             slot_cnt;
    logic [4:0]              ch;
    logic                    start;
    logic [15:0]             tick_cnt;
    logic                    tick;
    logic                    toggle_en;
    logic [1:0]              up_mode;
    logic [7:0]              port_en;
    logic [15:0]             port_mode;
    logic [15:0]             ovth;
    logic [7:0][11:0]        limit;
    logic [7:0]              oc_flag;
    logic [7:0]              oc_pend;
    logic [7:0]              oc_off;
    logic [7:0]              ov_off;
    logic [7:0][6:0]         oc_tmr;
    logic [7:0][6:0]         rec_tmr;
    logic [7:0][1:0]         ov_run;
    logic                    prev_enum;
    hpps_tg_t                tg;
    logic [6:0]              tg_tmr;
    logic [7:0]              tg_mask;
    logic [7:0]              pwr;
    logic [15:0]             offer;
    logic                    host_sel;
    logic [1:0]              route;
    logic [31:0]             rdata;
  } hpps_state_t;

  hpps_state_t r;
  hpps_state_t next_r;
  logic        upd;
  logic        enm;
  logic [2:0]  up;
  logic [4:0]  rd_ch;
  logic [15:0] meas_val;
  logic        bad;
  logic        over;

  function automatic hpps_offer_t offer_f(input logic [1:0] cfg, input logic en);
    if (en) begin
      offer_f = (cfg == CFG_CDP || cfg == CFG_CDP_DCP) ? OFFER_CDP : OFFER_SDP;
    end else begin
      offer_f = (cfg == CFG_SDP) ? OFFER_NONE : OFFER_DCP;
    end
  endfunction

  function automatic logic in_win(input logic [7:0] a, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_win = (a >= lo) && (a < hi);
  endfunction

  assign upd = (r.slot_cnt == SLOT_LAST);
  assign up = r.ch[3:1];
  assign enm = r.host_sel ? r.sy[SY_UP2E] : r.sy[SY_UP1E];
  assign rd_ch = 5'((reg_addr_in - REG_MEAS_BASE) >> 2);
  assign over = $signed(adc_data_in) > $signed({4'h0, r.limit[up]});
  assign bad = r.ch[0] ? adc_data_in[SW-1] : ($signed(adc_data_in) > $signed(r.ovth));

  hpps_ema u_ema (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .upd_in     (upd),
    .ch_in      (r.ch),
    .sample_in  (adc_data_in),
    .rd_ch_in   (rd_ch),
    .rd_val_out (meas_val)
  );

  always_comb begin
    next_r = r;
    // Three stages; a change counts once the last two agree
    next_r.s1 = {upstream_port_second_enum_in, upstream_port_first_enum_in,
                 upstream_port_second_conn_in, upstream_port_first_conn_in,
                 ctrl_cable_in, bus_powered_in};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < NSYNC; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.sy[i] = r.s2[i];
      end
    end

    // Millisecond tick for the slow timers
    next_r.tick = 1'b0;
    if (r.tick_cnt == 16'(TICK_CYC - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 16'h0001;
    end

    // Fixed slot sequencer over all ports, then the supply
    next_r.start = upd;
    if (upd) begin
      next_r.slot_cnt = '0;
      next_r.ch = (r.ch == CH_SUPPLY) ? 5'h00 : r.ch + 5'h01;
    end else begin
      next_r.slot_cnt = r.slot_cnt + 12'h001;
    end

    // Slow timers
    for (int p = 0; p < NPORT; p++) begin
      if (r.tick && r.oc_pend[p]) begin
        if (r.oc_tmr[p] == 7'h01) begin
          next_r.oc_pend[p] = 1'b0;
          next_r.oc_off[p] = 1'b1;
        end
        next_r.oc_tmr[p] = r.oc_tmr[p] - 7'h01;
      end
      if (r.tick && r.ov_off[p] && r.ov_run[p] == 2'h0) begin
        if (r.rec_tmr[p] == 7'h01) begin
          next_r.ov_off[p] = 1'b0;
        end
        next_r.rec_tmr[p] = r.rec_tmr[p] - 7'h01;
      end
    end

    // Per-sample fault checks on raw data
    if (upd && r.ch != CH_SUPPLY) begin
      if (r.ch[0] && over && !r.oc_pend[up] && !r.oc_off[up]) begin
        next_r.oc_pend[up] = 1'b1;
        next_r.oc_tmr[up] = OC_TICKS;
      end
      if (bad) begin
        if (r.ov_run[up] != OV_RUN) begin
          next_r.ov_run[up] = r.ov_run[up] + 2'h1;
        end
        if (r.ov_run[up] >= OV_RUN - 2'h1) begin
          next_r.ov_off[up] = 1'b1;
        end
        // Any bad sample restarts the recovery wait
        next_r.rec_tmr[up] = REC_TICKS;
      end else begin
        next_r.ov_run[up] = 2'h0;
      end
    end

    // Enumeration change cycles power of SDP and CDP ports
    next_r.prev_enum = enm;
    case (r.tg)
      TG_IDLE: begin
        if (enm != r.prev_enum && r.toggle_en) begin
          next_r.tg = TG_OFF;
          next_r.tg_tmr = CYCLE_TICKS;
          for (int p = 0; p < NPORT; p++) begin
            next_r.tg_mask[p] = r.port_mode[2*p +: 2] != CFG_DCP;
          end
        end
      end
      TG_OFF: begin
        if (enm != r.prev_enum) begin
          next_r.tg_tmr = CYCLE_TICKS;
        end else if (r.tick) begin
          next_r.tg_tmr = r.tg_tmr - 7'h01;
          if (r.tg_tmr == 7'h01) begin
            next_r.tg = TG_IDLE;
          end
        end
      end
      default: next_r.tg = TG_IDLE;
    endcase

    // Power and offered charging mode per port
    for (int p = 0; p < NPORT; p++) begin
      next_r.pwr[p] = r.port_en[p] && !r.sy[SY_BUSPWR]
                      && !r.oc_off[p] && !r.ov_off[p]
                      && !(r.tg == TG_OFF && r.tg_mask[p])
                      && !(r.port_mode[2*p +: 2] == CFG_SDP && !enm);
      next_r.offer[2*p +: 2] = offer_f(r.port_mode[2*p +: 2], enm);
    end

    // One host at a time; the control port only carries the control link
    if (r.up_mode == UP_FIRST) begin
      next_r.host_sel = 1'b0;
    end else if (r.up_mode == UP_SECOND) begin
      next_r.host_sel = 1'b1;
    end else begin
      next_r.host_sel = !r.sy[SY_UP1C];
    end
    if (r.sy[SY_CTRL]) begin
      next_r.route = LINK_CTRL;
    end else begin
      next_r.route = r.host_sel ? LINK_UP_SECOND : LINK_UP_FIRST;
    end

    // Register writes
    if (reg_wr_in) begin
      if (reg_addr_in == REG_CTRL) begin
        next_r.toggle_en = reg_wdata_in[CTRL_TOGGLE_BIT];
        next_r.up_mode = reg_wdata_in[CTRL_UPMODE_LSB +: 2];
      end else if (reg_addr_in == REG_PORT_EN) begin
        next_r.port_en = reg_wdata_in[7:0];
      end else if (reg_addr_in == REG_PORT_MODE) begin
        next_r.port_mode = reg_wdata_in[15:0];
      end else if (reg_addr_in == REG_OC_FLAGS) begin
        for (int p = 0; p < NPORT; p++) begin
          // A trip in the same cycle keeps the flag
          if (reg_wdata_in[p] && !(upd && r.ch[0] && over && up == 3'(p))) begin
            next_r.oc_flag[p] = next_r.oc_off[p] && !r.oc_off[p];
            next_r.oc_off[p] = next_r.oc_off[p] && !r.oc_off[p];
          end
        end
      end else if (reg_addr_in == REG_OV_THRESH) begin
        next_r.ovth = reg_wdata_in[15:0];
      end else if (in_win(reg_addr_in, REG_LIMIT_BASE, REG_MEAS_BASE)) begin
        next_r.limit[reg_addr_in[4:2]] = reg_wdata_in[11:0];
      end
    end
    if (upd && r.ch != CH_SUPPLY && r.ch[0] && over) begin
      next_r.oc_flag[up] = 1'b1;
    end

    // Register reads, data in the following cycle only
    next_r.rdata = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == REG_CTRL) begin
        next_r.rdata = {29'h0, r.up_mode, r.toggle_en};
      end else if (reg_addr_in == REG_PORT_EN) begin
        next_r.rdata = {24'h0, r.port_en};
      end else if (reg_addr_in == REG_PORT_MODE) begin
        next_r.rdata = {16'h0, r.port_mode};
      end else if (reg_addr_in == REG_OC_FLAGS) begin
        next_r.rdata = {24'h0, r.oc_flag};
      end else if (reg_addr_in == REG_STATUS) begin
        next_r.rdata = {8'h0, r.sy[5:2], r.route, r.host_sel, enm, r.ov_off, r.pwr};
      end else if (reg_addr_in == REG_OV_THRESH) begin
        next_r.rdata = {16'h0, r.ovth};
      end else if (in_win(reg_addr_in, REG_LIMIT_BASE, REG_MEAS_BASE)) begin
        next_r.rdata = {20'h0, r.limit[reg_addr_in[4:2]]};
      end else if (in_win(reg_addr_in, REG_MEAS_BASE, REG_MEAS_END)) begin
        next_r.rdata = {{16{meas_val[SW-1]}}, meas_val};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
      r.toggle_en <= CTRL_TOGGLE_RST;
      r.up_mode <= UP_AUTO;
      r.port_en <= PORT_EN_RST;
      r.port_mode <= PORT_MODE_RST;
      r.ovth <= OV_THRESH_RST;
      r.limit <= {NPORT{LIMIT_RST}};
      r.tg <= TG_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata_out = r.rdata;
  assign adc_start_out = r.start;
  assign adc_chan_out = r.ch;
  assign port_power_out = r.pwr;
  assign port_offer_out = r.offer;
  assign host_sel_out = r.host_sel;
  assign link_route_out = r.route;

  // Checking helpers
  logic [11:0] gap;
  logic        seen;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gap <= '0;
      seen <= 1'b0;
    end else begin
      gap <= adc_start_out ? 12'h000 : gap + 12'h001;
      seen <= seen | adc_start_out;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  property p_slot;
    adc_start_out && seen |-> gap == SLOT_LAST;
  endproperty
  a_slot: assert property (p_slot) else $error("slot length wrong");

  property p_order;
    upd && r.ch != CH_SUPPLY |=> adc_chan_out == $past(adc_chan_out) + 5'h01;
  endproperty
  a_order: assert property (p_order) else $error("channel order wrong");

  property p_oc_flag;
    upd && r.ch == 5'h01 && over |=> r.oc_flag[0]
      ##1 (r.oc_flag[0] || $past(reg_wr_in && reg_addr_in == REG_OC_FLAGS && reg_wdata_in[0]));
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag missing");

  property p_sticky;
    r.oc_flag[0] && !(reg_wr_in && reg_addr_in == REG_OC_FLAGS) |=> r.oc_flag[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_oc_off;
    $rose(r.oc_off[0]) |=> !port_power_out[0]
      ##1 (!port_power_out[0] || $past(reg_wr_in && reg_addr_in == REG_OC_FLAGS, 2));
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("port not cut on trip");

  property p_busp;
    r.sy[SY_BUSPWR] |=> port_power_out == 8'h00;
  endproperty
  a_busp: assert property (p_busp) else $error("power with bus supply");

  property p_sdp;
    !enm && r.port_mode[1:0] == CFG_SDP && $stable(enm) |=> !port_power_out[0];
  endproperty
  a_sdp: assert property (p_sdp) else $error("SDP powered unenumerated");

  property p_ov;
    upd && r.ch[3:1] == 3'h0 && r.ch != CH_SUPPLY && bad && r.ov_run[0] == 2'h2
      |=> r.ov_off[0] ##1 !port_power_out[0];
  endproperty
  a_ov: assert property (p_ov) else $error("third bad sample ignored");

  property p_auto;
    r.up_mode == UP_AUTO && r.sy[SY_UP1C] |=> !host_sel_out;
  endproperty
  a_auto: assert property (p_auto) else $error("first upstream not chosen");

  property p_link;
    r.sy[SY_CTRL] |=> link_route_out == LINK_CTRL;
  endproperty
  a_link: assert property (p_link) else $error("control link not on control port");

  c_oc: cover property ($rose(r.oc_off[0]));
  c_ov: cover property ($fell(r.ov_off[0]));
  c_tg: cover property (r.tg == TG_OFF);
  c_wrap: cover property (upd && r.ch == CH_SUPPLY);
endmodule

// [test/hpps_adc_model.sv]
// Far-side converter model returning one code for voltages, one for currents
`timescale 1ns/1ns
module hpps_adc_model (
  input  wire logic        clk_sys_in,
  input  wire logic [4:0]  adc_chan_in,
  input  wire logic [15:0] volt_val_in,
  input  wire logic [15:0] cur_val_in,
  output logic      [15:0] adc_data_out
);
  // Converts every cycle, so even the first slot after reset sees a real code
  always_ff @(posedge clk_sys_in) begin
    adc_data_out <= adc_chan_in[0] ? cur_val_in : volt_val_in;
  end
endmodule

// [test/tb_top.sv]
// Self-checking bench for the hub port power supervisor
`timescale 1ns/1ns
module tb_top;
  import hpps_pkg::*;
  logic             clk_sys_in;
  logic             arst_n_in;
  logic [7:0]       reg_addr_in;
  logic [31:0]      reg_wdata_in;
  logic             reg_wr_in;
  logic             reg_rd_in;
  logic [31:0]      reg_rdata_out;
  logic             adc_start_out;
  logic [4:0]       adc_chan_out;
  logic [SW-1:0]    adc_data_in;
  logic             bus_powered_in;
  logic             ctrl_cable_in;
  logic             up_first_conn;
  logic             up_second_conn;
  logic             up_first_enum;
  logic             up_second_enum;
  logic [NPORT-1:0] port_power_out;
  logic [15:0]      port_offer_out;
  logic             host_sel_out;
  logic [1:0]       link_route_out;
  int               errors;
  int               samples_checked;
  int               cycles;

  hpps_sup #(.TICK_CYC(20)) hpps_sup_inst (
    .clk_sys_in                   (clk_sys_in),
    .arst_n_in                    (arst_n_in),
    .reg_addr_in                  (reg_addr_in),
    .reg_wdata_in                 (reg_wdata_in),
    .reg_wr_in                    (reg_wr_in),
    .reg_rd_in                    (reg_rd_in),
    .reg_rdata_out                (reg_rdata_out),
    .adc_start_out                (adc_start_out),
    .adc_chan_out                 (adc_chan_out),
    .adc_data_in                  (adc_data_in),
    .bus_powered_in               (bus_powered_in),
    .ctrl_cable_in                (ctrl_cable_in),
    .upstream_port_first_conn_in  (up_first_conn),
    .upstream_port_second_conn_in (up_second_conn),
    .upstream_port_first_enum_in  (up_first_enum),
    .upstream_port_second_enum_in (up_second_enum),
    .port_power_out               (port_power_out),
    .port_offer_out               (port_offer_out),
    .host_sel_out                 (host_sel_out),
    .link_route_out               (link_route_out)
  );

  hpps_adc_model hpps_adc_model_inst (
    .clk_sys_in   (clk_sys_in),
    .adc_chan_in  (adc_chan_out),
    .volt_val_in  (16'h0190),
    .cur_val_in   (16'h0190),
    .adc_data_out (adc_data_in)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic test_done;
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard; the whole run needs well under half of this
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ends on a falling edge so outputs are settled for checks
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    @(negedge clk_sys_in);
    d = reg_rdata_out;
  endtask

  task automatic t_reset_values;
    logic [7:0]  a [7] = '{REG_CTRL, REG_PORT_EN, REG_PORT_MODE, REG_OV_THRESH,
                           REG_LIMIT_BASE, REG_OC_FLAGS, 8'hFC};
    logic [31:0] e [7] = '{32'h1, 32'hFF, 32'h0, 32'h2A3, 32'hFFF, 32'h0, 32'h0};
    logic [31:0] d;
    check(port_power_out, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(a[i], d);
      check(d, e[i]);
    end
  endtask

  task automatic t_charging;
    wr(REG_LIMIT_BASE, 32'h64);
    wr(REG_PORT_MODE, 32'hE4);
    cyc(4);
    check(port_power_out[0], 1'b0);
    check(port_offer_out[5:4], OFFER_DCP);
    check(port_offer_out[7:6], OFFER_DCP);
    @(posedge clk_sys_in);
    up_first_conn <= 1'b1;
    up_first_enum <= 1'b1;
    // Toggle holds all but the DCP port off for about 101 ticks of 20 cycles
    cyc(1000);
    check(port_power_out[0], 1'b0);
    check(port_power_out[3], 1'b1);
    cyc(1200);
    check(port_power_out[0], 1'b1);
    check(port_offer_out[3:2], OFFER_CDP);
    check(port_offer_out[1:0], OFFER_SDP);
    check(port_offer_out[5:4], OFFER_CDP);
    check(link_route_out, LINK_UP_FIRST);
  endtask

  task automatic t_adc;
    logic [4:0]  c;
    logic [31:0] d;
    int          n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (adc_start_out !== 1'b1 && n < 4000);
    c = adc_chan_out;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (adc_start_out !== 1'b1 && n < 4000);
    check(n, 3500);
    check(adc_chan_out, c + 5'h1);
    rd(REG_MEAS_BASE + {1'b0, c, 2'b00}, d);
    check(d, 32'h64);
  endtask

  // Port 0 current code 400 exceeds its limit of 100 on the first sample
  task automatic t_overcurrent;
    logic [31:0] d;
    rd(REG_OC_FLAGS, d);
    check(d, 32'h1);
    check(port_power_out[0], 1'b1);
    cyc(60);
    check(port_power_out, 8'hFE);
    cyc(100);
    rd(REG_OC_FLAGS, d);
    check(d, 32'h1);
    check(port_power_out[0], 1'b0);
    wr(REG_OC_FLAGS, 32'h1);
    cyc(8);
    rd(REG_OC_FLAGS, d);
    check(d, 32'h0);
    check(port_power_out[0], 1'b1);
  endtask

  task automatic t_host;
    @(posedge clk_sys_in);
    up_second_conn <= 1'b1;
    up_second_enum <= 1'b1;
    cyc(8);
    check(host_sel_out, 1'b0);
    @(posedge clk_sys_in);
    up_first_conn <= 1'b0;
    cyc(8);
    check(host_sel_out, 1'b1);
    check(link_route_out, LINK_UP_SECOND);
    check(port_offer_out[3:2], OFFER_CDP);
    check(port_power_out[0], 1'b1);
    @(posedge clk_sys_in);
    ctrl_cable_in <= 1'b1;
    cyc(8);
    check(link_route_out, LINK_CTRL);
    check(host_sel_out, 1'b1);
    wr(REG_CTRL, 32'h3);
    cyc(4);
    check(host_sel_out, 1'b0);
    wr(REG_CTRL, 32'h5);
    cyc(4);
    check(host_sel_out, 1'b1);
  endtask

  task automatic t_bus_power;
    @(posedge clk_sys_in);
    bus_powered_in <= 1'b1;
    cyc(8);
    check(port_power_out, 8'h00);
  endtask

  initial begin
    errors          = 0;
    samples_checked = 0;
    cycles          = 0;
    arst_n_in       = 1'b0;
    reg_addr_in     = 8'h00;
    reg_wdata_in    = 32'h0;
    reg_wr_in       = 1'b0;
    reg_rd_in       = 1'b0;
    bus_powered_in  = 1'b0;
    ctrl_cable_in   = 1'b0;
    up_first_conn   = 1'b0;
    up_second_conn  = 1'b0;
    up_first_enum   = 1'b0;
    up_second_enum  = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    cyc(1);
    t_reset_values;
    t_charging;
    t_adc;
    t_overcurrent;
    t_host;
    t_bus_power;
    test_done;
  end
endmodule
